// *** src/flash_cfg_host.sv ***
// Host end: configuration receiver and indirect programming sequencer
`include "flash_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_cfg_host (
	input  wire logic                  core_clk,
	input  wire logic                  reset_n,
	input  wire logic                  prog_reset_n,
	input  wire logic                  init_hold,
	input  wire logic                  cfg_run,
	output logic                       width_ok,
	output flash_cfg_pkg::word_t       cfg_word,
	output logic                       cfg_word_valid,
	input  wire logic                  req_valid,
	input  wire logic                  req_write,
	input  wire flash_cfg_pkg::host_addr_t req_addr,
	input  wire flash_cfg_pkg::word_t  req_wdata,
	output logic                       req_ready,
	output logic                       rsp_valid,
	output flash_cfg_pkg::word_t       rsp_rdata,
	flash_link_if.host_end             lnk
);

	logic                       rdy_s;
	flash_cfg_pkg::word_t       dq_s;
	flash_cfg_pkg::host_state_t st_r;
	logic [3:0]                 div_r;
	logic [3:0]                 tmr_r;
	logic                       tb_r;
	logic                       armed_r;
	logic                       wr_r;
	logic                       rst_n_r;
	flash_cfg_pkg::host_addr_t  addr_r;
	flash_cfg_pkg::word_t       wdata_r;
	logic                       tb_rise;
	logic                       tb_run;

	pin_sync #(
		.W   (17),
		.RST (17'h0_0000)
	) u_in_sync (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.pin_in       ({lnk.rdy_line, lnk.dq_line}),
		.pin_sync_out ({rdy_s, dq_s})
	);

	// Timebase runs only in configuration, never during indirect access
	assign tb_run  = cfg_run && rdy_s && (st_r == flash_cfg_pkg::ST_IDLE);
	assign tb_rise = tb_run && !tb_r && (div_r == 4'(`TB_HALF_CYC - 1));

	// Divider for the single timebase both ends share
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			div_r <= 4'h0;
			tb_r  <= 1'b0;
		end else if (!tb_run) begin
			div_r <= 4'h0;
			tb_r  <= 1'b0;
		end else if (div_r == 4'(`TB_HALF_CYC - 1)) begin
			div_r <= 4'h0;
			tb_r  <= ~tb_r;
		end else begin
			div_r <= div_r + 4'h1;
		end
	end

	// Word capture one rising edge after the device drove it
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			armed_r        <= 1'b0;
			width_ok       <= 1'b0;
			cfg_word       <= `DQ_RST;
			cfg_word_valid <= 1'b0;
		end else if (!cfg_run || !rdy_s) begin
			armed_r        <= 1'b0;
			width_ok       <= 1'b0;
			cfg_word_valid <= 1'b0;
		end else begin
			cfg_word_valid <= 1'b0;
			if (tb_rise) begin
				armed_r <= 1'b1;
				if (armed_r && !width_ok && dq_s[7:0] == `WIDTH_PATTERN) begin
					width_ok <= 1'b1;
				end
				if (armed_r && width_ok) begin
					cfg_word       <= dq_s;
					cfg_word_valid <= 1'b1;
				end
			end
		end
	end

	// Flash reset line follows the user level through a flop
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_n_r <= 1'b0;
		end else begin
			rst_n_r <= prog_reset_n;
		end
	end

	// Asynchronous access sequencer: setup, strobe, hold
	assign req_ready = !cfg_run && (st_r == flash_cfg_pkg::ST_IDLE);

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r      <= flash_cfg_pkg::ST_IDLE;
			tmr_r     <= 4'h0;
			wr_r      <= 1'b0;
			addr_r    <= 26'h000_0000;
			wdata_r   <= `DQ_RST;
			rsp_valid <= 1'b0;
			rsp_rdata <= `DQ_RST;
		end else begin
			rsp_valid <= 1'b0;
			tmr_r     <= tmr_r + 4'h1;
			unique case (st_r)
				flash_cfg_pkg::ST_IDLE: begin
					tmr_r <= 4'h0;
					if (req_valid && req_ready) begin
						wr_r    <= req_write;
						addr_r  <= req_addr;
						wdata_r <= req_wdata;
						st_r    <= flash_cfg_pkg::ST_SETUP;
					end
				end
				flash_cfg_pkg::ST_SETUP: begin
					if (tmr_r == 4'(`SETUP_CYC - 1)) begin
						tmr_r <= 4'h0;
						st_r  <= flash_cfg_pkg::ST_STROBE;
					end
				end
				flash_cfg_pkg::ST_STROBE: begin
					if (tmr_r == 4'(`STROBE_CYC - 1)) begin
						tmr_r     <= 4'h0;
						rsp_rdata <= wr_r ? wdata_r : dq_s;
						st_r      <= flash_cfg_pkg::ST_HOLD;
					end
				end
				flash_cfg_pkg::ST_HOLD: begin
					if (tmr_r == 4'(`HOLD_CYC - 1)) begin
						rsp_valid <= 1'b1;
						st_r      <= flash_cfg_pkg::ST_IDLE;
					end
				end
			endcase
		end
	end

	// Pin drive: configuration levels, else sequencer levels
	always_comb begin
		lnk.host_chip_select_n  = 1'b1;
		lnk.host_write_strobe_n = 1'b1;
		lnk.host_output_drive_n = 1'b1;
		lnk.addr_latch_n        = 1'b1;
		lnk.dq_host_oe_n        = 1'b1;
		if (cfg_run) begin
			lnk.host_chip_select_n  = 1'b0;
			lnk.host_output_drive_n = 1'b0;
		end else if (st_r != flash_cfg_pkg::ST_IDLE) begin
			lnk.host_chip_select_n = 1'b0;
			lnk.addr_latch_n       = (st_r == flash_cfg_pkg::ST_HOLD);
			lnk.dq_host_oe_n       = !wr_r;
			if (st_r == flash_cfg_pkg::ST_STROBE) begin
				lnk.host_write_strobe_n = !wr_r;
				lnk.host_output_drive_n = wr_r;
			end
		end
	end

	assign lnk.receiver_cfg_timebase = tb_r;
	assign lnk.flash_reset_n         = rst_n_r;
	assign lnk.addr                  = cfg_run ? 26'h000_0000 : addr_r;
	assign lnk.dq_host_o             = wdata_r;
	assign lnk.rdy_host_o            = 1'b0;
	assign lnk.rdy_host_oe_n         = !init_hold;

endmodule : flash_cfg_host

`default_nettype wire

// *** src/flash_cfg_consts.svh ***
// Constants for the flash configuration stream and its host end
`ifndef FLASH_CFG_CONSTS_SVH
`define FLASH_CFG_CONSTS_SVH

// Widths of the shared buses
`define DQ_W              16
`define FLASH_ADDR_W      23
`define HOST_ADDR_W       26

// Implemented array storage, word address bits actually decoded
`define MEM_AW            10
`define MEM_WORDS         1024

// Start address seen on the address pins, which the host drives to zero in configuration
`define START_ADDR        23'h00_0000

// Reset values
`define DQ_RST            16'h0000
`define CNT_RST           23'h00_0000

// Low-byte pattern that marks a 16-bit bus
`define WIDTH_PATTERN     8'hD5

// Core clock period and host-side timing
`define CLK_PERIOD_NS     10
`define TB_HALF_NS        80
`define TB_HALF_CYC       (`TB_HALF_NS / `CLK_PERIOD_NS)
`define SETUP_NS          60
`define SETUP_CYC         (`SETUP_NS / `CLK_PERIOD_NS)
`define STROBE_NS         100
`define STROBE_CYC        (`STROBE_NS / `CLK_PERIOD_NS)
`define HOLD_NS           60
`define HOLD_CYC          (`HOLD_NS / `CLK_PERIOD_NS)

`endif

// *** src/flash_cfg_pkg.sv ***
// Types shared by both ends of the flash configuration link
package flash_cfg_pkg;

	typedef logic [15:0] word_t;
	typedef logic [22:0] flash_addr_t;
	typedef logic [25:0] host_addr_t;

	// Host access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD   = 2'b11
	} host_state_t;

endpackage : flash_cfg_pkg

// *** src/flash_link_if.sv ***
// Pin-level link between the flash device end and its host end
`timescale 1ns/1ps
`default_nettype none

interface flash_link_if;

	logic                     receiver_cfg_timebase;
	logic                     flash_reset_n;
	logic                     host_chip_select_n;
	logic                     host_write_strobe_n;
	logic                     host_output_drive_n;
	logic                     addr_latch_n;
	flash_cfg_pkg::host_addr_t addr;
	// Open-drain ready/init line, low enable drives
	logic                     rdy_dev_o;
	logic                     rdy_dev_oe_n;
	logic                     rdy_host_o;
	logic                     rdy_host_oe_n;
	logic                     rdy_line;
	// Shared data bus, low enable drives
	flash_cfg_pkg::word_t     dq_dev_o;
	logic                     dq_dev_oe_n;
	flash_cfg_pkg::word_t     dq_host_o;
	logic                     dq_host_oe_n;
	flash_cfg_pkg::word_t     dq_line;

	// Pull-up on the ready line, wired-and of both drivers
	assign rdy_line = (rdy_dev_oe_n | rdy_dev_o) & (rdy_host_oe_n | rdy_host_o);

	// Pull-down on an idle data bus; device wins a clash
	assign dq_line = !dq_dev_oe_n ? dq_dev_o :
		(!dq_host_oe_n ? dq_host_o : 16'h0000);

	modport flash_end (
		input  receiver_cfg_timebase, flash_reset_n, host_chip_select_n,
		input  host_write_strobe_n, host_output_drive_n, addr_latch_n, addr,
		input  rdy_line, dq_line,
		output rdy_dev_o, rdy_dev_oe_n, dq_dev_o, dq_dev_oe_n
	);

	modport host_end (
		output receiver_cfg_timebase, flash_reset_n, host_chip_select_n,
		output host_write_strobe_n, host_output_drive_n, addr_latch_n, addr,
		output rdy_host_o, rdy_host_oe_n, dq_host_o, dq_host_oe_n,
		input  rdy_line, dq_line
	);

endinterface : flash_link_if

`default_nettype wire

// *** src/flash_sync_config_stream.sv ***
// Flash device end: pin synchroniser and configuration stream logic
//
// Operation
// - Each timebase cycle: advance counter, drive word
// - Receiver samples word on next rising edge
// - Counter starts from address pins, zero
// - Upper three host address bits ignored
// - Chip enable high: strobes, latch and timebase ignored
// - Receiver detects x16 from the low byte, then takes all 16 lines
// - Write strobe high: no programming accepted
// - Output drive low, chip on: drive data
// - Indirect access asynchronous, timebase unused
// - Host toggles strobes, moves data over DQ
// - One timebase source drives both ends
// - Ready line rising edge latches start address
// - Flash reset line resets access logic
// - Chip enabled while chip select low
// - Latch high blocks indirect address loads, not the ready-rise start load
`include "flash_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         core_clk,
	input  wire logic         reset_n,
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_sync_out
);

	logic [W-1:0] meta_r;

	// Two-stage synchroniser; only the second stage is seen
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r       <= RST;
			pin_sync_out <= RST;
		end else begin
			meta_r       <= pin_in;
			pin_sync_out <= meta_r;
		end
	end

endmodule : pin_sync

module flash_sync_config_stream (
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	output logic                            streaming,
	output flash_cfg_pkg::flash_addr_t      word_addr,
	flash_link_if.flash_end                 lnk
);

	// Control pins after synchronisation
	logic                        tb_s;
	logic                        rdy_s;
	logic                        ce_n_s;
	logic                        we_n_s;
	logic                        oe_n_s;
	logic                        lat_n_s;
	logic                        frst_n_s;
	flash_cfg_pkg::flash_addr_t  addr_s;
	flash_cfg_pkg::word_t        dq_s;

	// Edge history and state
	logic                        tb_q_r;
	logic                        rdy_q_r;
	logic                        we_q_r;
	logic                        stream_r;
	logic                        por_done_r;
	logic                        oe_n_r;
	flash_cfg_pkg::flash_addr_t  cnt_r;
	flash_cfg_pkg::word_t        data_r;
	flash_cfg_pkg::word_t        mem_r [0:`MEM_WORDS-1];

	logic                        tb_rise;
	logic                        rdy_rise;
	logic                        we_rise;
	logic                        chip_on;
	logic                        acc_rst;
	logic [`MEM_AW-1:0]          mem_idx;

	// Control pins reset to their inactive levels, except flash reset, which resets low (active)
	// Ready starts low like the line during reset, so no false rise follows
	pin_sync #(
		.W   (7),
		.RST (7'h1E)
	) u_ctrl_sync (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.pin_in       ({lnk.receiver_cfg_timebase, lnk.rdy_line,
		                lnk.host_chip_select_n, lnk.host_write_strobe_n,
		                lnk.host_output_drive_n, lnk.addr_latch_n,
		                lnk.flash_reset_n}),
		.pin_sync_out ({tb_s, rdy_s, ce_n_s, we_n_s, oe_n_s, lat_n_s, frst_n_s})
	);

	// Only the low 23 address lines reach the counter
	pin_sync #(
		.W   (39),
		.RST (39'h00_0000_0000)
	) u_bus_sync (
		.core_clk     (core_clk),
		.reset_n      (reset_n),
		.pin_in       ({lnk.addr[22:0], lnk.dq_line}),
		.pin_sync_out ({addr_s, dq_s})
	);

	// Events and qualifiers
	assign tb_rise  = tb_s & ~tb_q_r;
	assign rdy_rise = rdy_s & ~rdy_q_r;
	assign we_rise  = we_n_s & ~we_q_r;
	assign chip_on  = ~ce_n_s;
	assign acc_rst  = ~frst_n_s;
	assign mem_idx  = cnt_r[`MEM_AW-1:0];

	// Edge history of the synchronised pins
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			tb_q_r  <= 1'b0;
			rdy_q_r <= 1'b0;
			we_q_r  <= 1'b1;
		end else begin
			tb_q_r  <= tb_s;
			rdy_q_r <= rdy_s;
			we_q_r  <= we_n_s;
		end
	end

	// Own power-on hold of the ready line, released one edge after reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			por_done_r <= 1'b0;
		end else begin
			por_done_r <= 1'b1;
		end
	end

	// Streaming runs from the ready rise until the line drops or a reset
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stream_r <= 1'b0;
		end else if (acc_rst || !rdy_s) begin
			stream_r <= 1'b0;
		end else if (rdy_rise) begin
			stream_r <= 1'b1;
		end
	end

	// Address counter: start latch, async latch, stream advance
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_r <= `CNT_RST;
		end else if (acc_rst) begin
			cnt_r <= `CNT_RST;
		end else if (rdy_rise) begin
			cnt_r <= addr_s;
		end else if (chip_on && !lat_n_s) begin
			cnt_r <= addr_s;
		end else if (stream_r && chip_on && tb_rise) begin
			cnt_r <= cnt_r + 23'h00_0001;
		end
	end

	// Output word register; the receiver samples it one edge later
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_r <= `DQ_RST;
		end else if (acc_rst) begin
			data_r <= `DQ_RST;
		end else if (stream_r && chip_on && tb_rise) begin
			data_r <= mem_r[mem_idx];
		end else if (!stream_r && chip_on && !oe_n_s && we_n_s) begin
			data_r <= mem_r[mem_idx];
		end
	end

	// Array write at the end of a write pulse; never while streaming
	// Direct word write keeps programming simple: no command set
	always_ff @(posedge core_clk) begin
		if (frst_n_s && chip_on && we_rise && oe_n_s && !stream_r) begin
			mem_r[mem_idx] <= dq_s;
		end
	end

	// Bus drive only while selected and output drive requested
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			oe_n_r <= 1'b1;
		end else begin
			oe_n_r <= ce_n_s | oe_n_s | acc_rst;
		end
	end

	// Pin outputs
	assign lnk.dq_dev_o     = data_r;
	assign lnk.dq_dev_oe_n  = oe_n_r;
	assign lnk.rdy_dev_o    = 1'b0;
	assign lnk.rdy_dev_oe_n = por_done_r & frst_n_s;

	// Status
	assign streaming = stream_r;
	assign word_addr = cnt_r;

endmodule : flash_sync_config_stream

`default_nettype wire

// *** testbench/flash_cfg_link_checker.sv ***
// Pin-level checks on the link between flash end and host end
`timescale 1ns/1ps
`default_nettype none

module flash_cfg_link_checker (
	input wire logic                      core_clk,
	input wire logic                      reset_n,
	input wire logic                      receiver_cfg_timebase,
	input wire logic                      flash_reset_n,
	input wire logic                      host_chip_select_n,
	input wire logic                      host_write_strobe_n,
	input wire logic                      host_output_drive_n,
	input wire logic                      addr_latch_n,
	input wire flash_cfg_pkg::host_addr_t addr,
	input wire logic                      rdy_line,
	input wire logic                      dq_dev_oe_n,
	input wire logic                      dq_host_oe_n
);

	// Single clock domain; pin synchronisers give up to three cycles of lag
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	ce_release_a: assert property (host_chip_select_n [*5] |-> dq_dev_oe_n)
		else $error("data bus driven while chip deselected");
	oe_release_a: assert property (host_output_drive_n [*5] |-> dq_dev_oe_n)
		else $error("data bus driven while output drive off");
	read_drive_a: assert property (
		(!host_chip_select_n && !host_output_drive_n && flash_reset_n) [*5] |-> !dq_dev_oe_n)
		else $error("data bus not driven while selected and enabled");
	no_clash_a: assert property (!dq_host_oe_n |-> dq_dev_oe_n)
		else $error("both ends drive the data bus");
	write_strobe_a: assert property ($fell(host_write_strobe_n) |->
		(!host_write_strobe_n && !dq_host_oe_n && !host_chip_select_n) [*8]
		##1 !host_write_strobe_n ##1 !host_write_strobe_n ##1 host_write_strobe_n)
		else $error("write strobe shape wrong");
	write_vs_read_a: assert property (!host_write_strobe_n |-> host_output_drive_n)
		else $error("write strobe with output drive on");
	clock_still_a: assert property (!addr_latch_n |-> !receiver_cfg_timebase)
		else $error("timebase runs during indirect access");
	cfg_pins_a: assert property (receiver_cfg_timebase |-> addr_latch_n &&
		host_write_strobe_n && !host_output_drive_n && addr == 26'h000_0000)
		else $error("configuration pin levels wrong");
	half_period_a: assert property ($rose(receiver_cfg_timebase) |->
		(receiver_cfg_timebase || !rdy_line) [*6])
		else $error("timebase high phase too short");

endmodule : flash_cfg_link_checker

`default_nettype wire

// *** testbench/tb_flash_sync_config_stream.sv ***
// Self-checking bench joining the flash end and the host end
`include "flash_cfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_flash_sync_config_stream;

	localparam int K = 12;

	logic                      core_clk = 1'b0;
	logic                      reset_n;
	logic                      prog_reset_n;
	logic                      init_hold;
	logic                      cfg_run;
	logic                      req_valid;
	logic                      req_write;
	flash_cfg_pkg::host_addr_t req_addr;
	flash_cfg_pkg::word_t      req_wdata;
	logic                      req_ready;
	logic                      rsp_valid;
	flash_cfg_pkg::word_t      rsp_rdata;
	logic                      width_ok;
	flash_cfg_pkg::word_t      cfg_word;
	logic                      cfg_word_valid;
	logic                      streaming;
	flash_cfg_pkg::flash_addr_t word_addr;
	flash_cfg_pkg::word_t      exp_mem [K];
	flash_cfg_pkg::word_t      got [$];
	flash_cfg_pkg::word_t      rd;
	int                        errors = 0;
	int                        checked = 0;
	int                        seed = 69;
	int                        n;

	// 100 MHz core clock
	always #5 core_clk = ~core_clk;

	flash_link_if lnk_i ();

	flash_sync_config_stream u_flash_sync_config_stream (
		.core_clk (core_clk), .reset_n (reset_n), .streaming (streaming),
		.word_addr (word_addr), .lnk (lnk_i)
	);

	flash_cfg_host u_flash_cfg_host (
		.core_clk (core_clk), .reset_n (reset_n), .prog_reset_n (prog_reset_n),
		.init_hold (init_hold), .cfg_run (cfg_run), .width_ok (width_ok),
		.cfg_word (cfg_word), .cfg_word_valid (cfg_word_valid),
		.req_valid (req_valid), .req_write (req_write), .req_addr (req_addr),
		.req_wdata (req_wdata), .req_ready (req_ready), .rsp_valid (rsp_valid),
		.rsp_rdata (rsp_rdata), .lnk (lnk_i)
	);

	flash_cfg_link_checker u_flash_cfg_link_checker (
		.core_clk (core_clk), .reset_n (reset_n),
		.receiver_cfg_timebase (lnk_i.receiver_cfg_timebase),
		.flash_reset_n (lnk_i.flash_reset_n),
		.host_chip_select_n (lnk_i.host_chip_select_n),
		.host_write_strobe_n (lnk_i.host_write_strobe_n),
		.host_output_drive_n (lnk_i.host_output_drive_n),
		.addr_latch_n (lnk_i.addr_latch_n), .addr (lnk_i.addr),
		.rdy_line (lnk_i.rdy_line), .dq_dev_oe_n (lnk_i.dq_dev_oe_n),
		.dq_host_oe_n (lnk_i.dq_host_oe_n)
	);

	// Delivered words; sampled at the edge so the one-cycle pulse is never missed
	always @(posedge core_clk) begin
		if (cfg_word_valid === 1'b1) begin
			got.push_back(cfg_word);
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask : chk

	// Response pulse shows after setup, strobe and hold phases have run out
	function automatic int acc_latency();
		return `SETUP_CYC + `STROBE_CYC + `HOLD_CYC;
	endfunction : acc_latency

	// One indirect access; response latency is fixed by the sequencer
	task automatic acc(input logic w, input flash_cfg_pkg::host_addr_t a,
		input flash_cfg_pkg::word_t d, output flash_cfg_pkg::word_t r);
		int c;
		@(posedge core_clk);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr  <= a;
		req_wdata <= d;
		@(posedge core_clk);
		req_valid <= 1'b0;
		c = 0;
		do begin
			@(posedge core_clk);
			#1;
			c++;
		end while (rsp_valid !== 1'b1 && c < 40);
		chk(c, acc_latency());
		r = rsp_rdata;
	endtask : acc

	task automatic wait_words(input int cnt);
		n = 0;
		while (got.size() < cnt && n < 2000) begin
			@(posedge core_clk);
			n++;
		end
		chk(got.size() >= cnt, 1);
	endtask : wait_words

	task automatic print_verdict;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// Watchdog; the whole sequence needs about a thousand cycles
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		print_verdict();
	end

	initial begin
		reset_n = 1'b0;
		prog_reset_n = 1'b1;
		init_hold = 1'b1; // Ready low keeps the device out of streaming
		cfg_run = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		// Word 0 carries the width marker; upper address bits are junk
		for (int i = 0; i < K; i++) begin
			exp_mem[i] = 16'($random(seed));
			if (i == 0) exp_mem[i][7:0] = `WIDTH_PATTERN;
			acc(1'b1, {(i == K - 1) ? 3'b111 : 3'($random(seed)), 23'(i)}, exp_mem[i], rd);
			chk(rd, exp_mem[i]);
		end
		for (int i = 0; i < K; i++) begin
			acc(1'b0, {3'($random(seed)), 23'(i)}, 16'h0000, rd);
			chk(rd, exp_mem[i]);
		end
		// Ready held low: nothing may stream, host refuses access
		@(posedge core_clk);
		init_hold <= 1'b1;
		cfg_run <= 1'b1;
		repeat (80) @(posedge core_clk);
		#1;
		chk(req_ready, 0);
		chk(got.size(), 0);
		chk(streaming, 0);
		@(posedge core_clk);
		init_hold <= 1'b0;
		wait_words(K - 1);
		for (int j = 0; j < K - 1; j++) begin
			chk(got[j], exp_mem[j + 1]);
		end
		chk(width_ok, 1);
		// Flash reset mid-stream clears the counter
		@(posedge core_clk);
		prog_reset_n <= 1'b0;
		repeat (6) @(posedge core_clk);
		#1;
		chk(streaming, 0);
		chk(word_addr, 0);
		@(posedge core_clk);
		prog_reset_n <= 1'b1;
		init_hold <= 1'b1;
		repeat (8) @(posedge core_clk);
		init_hold <= 1'b0;
		// Fresh ready rise restarts from word zero
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (streaming !== 1'b1 && n < 100);
		chk(streaming, 1);
		chk(word_addr, 0);
		// Leave configuration with ready low so the timebase stops cleanly
		// Ready stays low: a streaming device would not load the addressed word for the indirect read
		repeat (40) @(posedge core_clk);
		init_hold <= 1'b1;
		repeat (10) @(posedge core_clk);
		cfg_run <= 1'b0;
		repeat (10) @(posedge core_clk);
		acc(1'b0, 26'h000_0003, 16'h0000, rd);
		chk(rd, exp_mem[3]);
		print_verdict();
	end

endmodule : tb_flash_sync_config_stream

`default_nettype wire
